// file: amb_host.sv
// Host controller driving an asynchronous SRAM-compatible nonvolatile memory
`timescale 1ns/1ps
// Function
// - Host may hold chip select low indefinitely
// - Write strobe high through power cycles
// - Protect sequence: address setup, address stable
// - Byte mode uses top address bit
// - Budget latency and precharge cycles
// - Chip select low during accesses and while the host holds the page open
module amb_host
  import amb_pkg::*;
#(
  parameter int ADDR_W = AMB_ADDR_W,
  parameter int DATA_W = AMB_DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_byte_mode,
  input wire logic [ADDR_W:0] req_addr,
  input wire logic [1:0] req_lane_en,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic req_hold_cs,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic [ADDR_W-1:0] mem_addr,
  output logic chip_select_n,
  output logic write_enable_n,
  output logic output_enable_n,
  output logic upper_byte_select_n,
  output logic lower_byte_select_n,
  input wire logic [DATA_W-1:0] mem_dq_in,
  output logic [DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe_n
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [ADDR_W-AMB_COL_W-1:0] row_of(input logic [ADDR_W-1:0] a);
    row_of = a[ADDR_W-1:AMB_COL_W];
  endfunction

  // Sequencer state and the request latched at take
  amb_state_e state_r, state_nxt;
  logic [3:0] cnt_r;
  logic open_r;
  logic wr_r;
  logic [1:0] lanes_r;
  logic capture;
  logic [DATA_W-1:0] rd_q;

  // Byte mode: top address bit picks the lane, both lanes joined
  wire logic top_address_bit = req_addr[ADDR_W];
  wire logic [1:0] lanes_req = req_byte_mode ? (top_address_bit ? 2'h2 : 2'h1) : req_lane_en;
  wire logic [DATA_W-1:0] wdata_req = req_byte_mode ? {req_wdata[7:0], req_wdata[7:0]} : req_wdata;
  // Same row in an open page: page access skips the setup count
  wire logic same_row = open_r && (row_of(req_addr[ADDR_W-1:0]) == row_of(mem_addr));
  wire logic take = req_ready && req_valid;
  wire logic cnt_done = (cnt_r == 4'h0);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      AMB_IDLE: begin
        if (take) state_nxt = AMB_SETUP;
      end
      AMB_SETUP: begin
        if (cnt_done) state_nxt = AMB_ACCESS;
      end
      AMB_ACCESS: begin
        if (cnt_done) state_nxt = AMB_DONE;
      end
      AMB_DONE: begin
        // Precharge unless the user keeps the page open
        state_nxt = req_hold_cs ? AMB_IDLE : AMB_PRECH;
      end
      AMB_PRECH: begin
        if (cnt_done) state_nxt = AMB_IDLE;
      end
      default: state_nxt = AMB_IDLE;
    endcase
  end

  // Read data taken on the last access edge, while the strobes still stand
  assign capture = (state_r == AMB_ACCESS) && cnt_done && !wr_r;

  // ----------------------------------------
  // Sequencer and pins
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= AMB_IDLE;
      cnt_r <= 4'h0;
      open_r <= 1'b0;
      wr_r <= 1'b0;
      lanes_r <= 2'h0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      mem_addr <= '0;
      chip_select_n <= 1'b1;
      write_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      upper_byte_select_n <= 1'b1;
      lower_byte_select_n <= 1'b1;
      mem_dq_out <= '0;
      mem_dq_oe_n <= 1'b1;
    end else begin
      state_r <= state_nxt;
      rsp_valid <= 1'b0;
      req_ready <= (state_nxt == AMB_IDLE);
      case (state_r)
        AMB_IDLE: begin
          if (take) begin
            // Address changes while chip select low; row change does not precharge
            mem_addr <= req_addr[ADDR_W-1:0];
            wr_r <= req_write;
            lanes_r <= lanes_req;
            mem_dq_out <= wdata_req;
            // Row change in an open page forces full setup
            cnt_r <= same_row ? 4'h0 : 4'(AMB_SETUP_CYC);
            upper_byte_select_n <= 1'b1;
            lower_byte_select_n <= 1'b1;
          end
        end
        AMB_SETUP: begin
          // Address is settled: assert strobes, address stays stable
          if (cnt_done) begin
            chip_select_n <= 1'b0;
            upper_byte_select_n <= !lanes_r[1];
            lower_byte_select_n <= !lanes_r[0];
            write_enable_n <= !wr_r;
            output_enable_n <= wr_r;
            mem_dq_oe_n <= !wr_r;
            cnt_r <= 4'(AMB_ACCESS_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        AMB_ACCESS: begin
          if (cnt_done) begin
            write_enable_n <= 1'b1;
            output_enable_n <= 1'b1;
            open_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        AMB_DONE: begin
          rsp_valid <= 1'b1;
          mem_dq_oe_n <= 1'b1;
          if (!req_hold_cs) begin
            // Chip select high starts the device precharge
            chip_select_n <= 1'b1;
            open_r <= 1'b0;
            cnt_r <= 4'(AMB_PRECHARGE_CYC - 1);
          end
        end
        AMB_PRECH: begin
          if (!cnt_done) cnt_r <= cnt_r - 4'h1;
        end
        default: ;
      endcase
    end
  end

  // Read data capture register
  amb_rdreg #(.DATA_W(DATA_W)) u_rdreg (
    .sys_clk(sys_clk),
    .rst(rst),
    .capture(capture),
    .lane_en(lanes_r),
    .din(mem_dq_in),
    .dout(rd_q)
  );
  assign rsp_rdata = rd_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Write strobe may only fall inside a selected access
  we_idle_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    (chip_select_n |-> write_enable_n)) else $error("write strobe low while deselected");
  we_reset_high_a: assert property (@(posedge sys_clk)
    (!rst && $past(rst)) |-> write_enable_n) else $error("write strobe low after reset");
  // Address held for the whole selected access
  addr_stable_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!chip_select_n && $past(!chip_select_n) && state_r != AMB_IDLE && $past(state_r) != AMB_IDLE)
    |-> $stable(mem_addr)) else $error("address moved during access");
  // Lanes: selects follow the latched lanes, no drive while the memory drives
  lane_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == AMB_ACCESS) |-> (upper_byte_select_n == !lanes_r[1] && lower_byte_select_n == !lanes_r[0]))
    else $error("byte selects mismatch lanes");
  oe_read_only_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!output_enable_n) |-> mem_dq_oe_n) else $error("bus fight read and drive");
  // Closed page keeps select high, so a protect sequence stays possible
  cs_release_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == AMB_DONE && !req_hold_cs) |=> chip_select_n) else $error("chip select not released");
  cs_driven_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == AMB_IDLE && !open_r) |-> chip_select_n) else $error("chip select low with page closed");
  // A new row always gets the full setup count
  row_setup_a: assert property (@(posedge sys_clk) disable iff (rst)
    (take && !same_row) |=> (cnt_r == 4'(AMB_SETUP_CYC))) else $error("row change without setup");
  // Answer is launched from DONE, one edge after the last access edge
  rsp_timing_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == AMB_ACCESS && cnt_done) |-> ##2 rsp_valid) else $error("response late");
  rsp_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    rsp_valid |=> !rsp_valid) else $error("response longer than one cycle");
  req_done_a: assert property (@(posedge sys_clk) disable iff (rst)
    take |-> ##[2:8] rsp_valid) else $error("request not answered");
  // Main scenarios
  cov_read_c: cover property (@(posedge sys_clk) disable iff (rst) rsp_valid && !wr_r);
  cov_write_c: cover property (@(posedge sys_clk) disable iff (rst) rsp_valid && wr_r);
  cov_page_c: cover property (@(posedge sys_clk) disable iff (rst) take && same_row);
  cov_byte_c: cover property (@(posedge sys_clk) disable iff (rst) take && req_byte_mode);
endmodule // amb_host

// file: amb_pkg.sv
// Package: constants for the async memory bus host controller
package amb_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int AMB_ADDR_W = 17;
  localparam int AMB_DATA_W = 16;
  localparam int AMB_COL_W = 2;
  localparam int AMB_ROW_COUNT = 32768;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int AMB_CLK_MHZ = 10;
  localparam int AMB_CLK_NS = 1000 / AMB_CLK_MHZ;
  localparam int ADDRESS_SETUP_TIME_NS = 10;
  localparam int AMB_SETUP_CYC = (ADDRESS_SETUP_TIME_NS + AMB_CLK_NS - 1) / AMB_CLK_NS;
  localparam int AMB_ACCESS_CYC = 1;
  localparam int AMB_PRECHARGE_CYC = 1;
  localparam int AMB_PAGE_MAX_MHZ = 33;
  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [2:0] {
    AMB_IDLE = 3'h0,
    AMB_SETUP = 3'h1,
    AMB_ACCESS = 3'h3,
    AMB_DONE = 3'h2,
    AMB_PRECH = 3'h6
  } amb_state_e;
endpackage

// file: amb_rdreg.sv
// Read-data capture register with byte-lane gating
`timescale 1ns/1ps
module amb_rdreg
  import amb_pkg::*;
#(
  parameter int DATA_W = AMB_DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic capture,
  input wire logic [1:0] lane_en,
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dout
);
  // ----------------------------------------
  // Capture only the selected byte lanes
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dout <= '0;
    end else if (capture) begin
      if (lane_en[0]) dout[7:0] <= din[7:0];
      if (lane_en[1]) dout[DATA_W-1:8] <= din[DATA_W-1:8];
    end
  end
endmodule // amb_rdreg

// file: amb_mem_model.sv
// Behavioural model of the asynchronous nonvolatile memory seen by the host
`timescale 1ns/1ps
module amb_mem_model
  import amb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [AMB_ADDR_W-1:0] mem_addr,
  input wire logic chip_select_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic upper_byte_select_n,
  input wire logic lower_byte_select_n,
  input wire logic [AMB_DATA_W-1:0] mem_dq_out,
  input wire logic mem_dq_oe_n,
  output logic [AMB_DATA_W-1:0] mem_dq_in
);
  logic [AMB_DATA_W-1:0] cells [0:(1<<AMB_ADDR_W)-1];
  logic [AMB_DATA_W-1:0] noise_r = 16'hA5C3;
  logic rd_on;
  // ----------------------------------------
  // Array
  // ----------------------------------------
  // Store per lane, so a deselected byte keeps its old value
  always @(posedge sys_clk) begin
    noise_r <= ~noise_r;
    // Data lands only while the host really drives the bus
    if (!chip_select_n && !write_enable_n && !mem_dq_oe_n) begin
      if (!upper_byte_select_n) cells[mem_addr][15:8] <= mem_dq_out[15:8];
      if (!lower_byte_select_n) cells[mem_addr][7:0] <= mem_dq_out[7:0];
    end
  end
  // Read follows any address change with no select toggle; idle lanes carry noise, not stale data
  assign rd_on = !chip_select_n && !output_enable_n && write_enable_n && mem_dq_oe_n;
  assign mem_dq_in[15:8] = (rd_on && !upper_byte_select_n) ? cells[mem_addr][15:8] : noise_r[15:8];
  assign mem_dq_in[7:0] = (rd_on && !lower_byte_select_n) ? cells[mem_addr][7:0] : noise_r[7:0];
endmodule // amb_mem_model

// file: testbench.sv
// Self-checking testbench for the async memory bus host controller
`timescale 1ns/1ps
module testbench
  import amb_pkg::*;
;
  logic sys_clk, rst, req_valid, req_write, req_byte_mode, req_hold_cs, req_ready, rsp_valid;
  logic [AMB_ADDR_W:0] req_addr;
  logic [1:0] req_lane_en;
  logic [15:0] req_wdata, rsp_rdata, mem_dq_in, mem_dq_out;
  logic [AMB_ADDR_W-1:0] mem_addr;
  logic chip_select_n, write_enable_n, output_enable_n, upper_byte_select_n, lower_byte_select_n, mem_dq_oe_n;
  int n_errors = 0;
  int checked = 0;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  amb_host dut_u (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_byte_mode(req_byte_mode), .req_addr(req_addr), .req_lane_en(req_lane_en), .req_wdata(req_wdata),
    .req_hold_cs(req_hold_cs), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mem_addr(mem_addr), .chip_select_n(chip_select_n), .write_enable_n(write_enable_n),
    .output_enable_n(output_enable_n), .upper_byte_select_n(upper_byte_select_n),
    .lower_byte_select_n(lower_byte_select_n), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out),
    .mem_dq_oe_n(mem_dq_oe_n));
  amb_mem_model mem_u (.sys_clk(sys_clk), .mem_addr(mem_addr), .chip_select_n(chip_select_n),
    .write_enable_n(write_enable_n), .output_enable_n(output_enable_n),
    .upper_byte_select_n(upper_byte_select_n), .lower_byte_select_n(lower_byte_select_n),
    .mem_dq_out(mem_dq_out), .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_in(mem_dq_in));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One request: wait for ready, count cycles to the answer, note which strobes went low
  // lat is the edge after take that raises rsp_valid; it is seen one negedge later
  task automatic xfer(input logic w, bm, hold, input logic [17:0] a, input logic [1:0] le,
      input logic [15:0] wd, input int lat, output logic [15:0] q);
    int n;
    logic [2:0] pins;
    logic [1:0] lanes;
    n = 0;
    pins = 3'b111;
    lanes = bm ? (a[17] ? 2'b10 : 2'b01) : le;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_byte_mode <= bm;
    req_hold_cs <= hold;
    req_addr <= a;
    req_lane_en <= le;
    req_wdata <= wd;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (chip_select_n === 1'b0) pins &= {write_enable_n, upper_byte_select_n, lower_byte_select_n};
    end while (rsp_valid !== 1'b1 && n < 20);
    chk(n - 1, lat);
    chk(pins, {~w, ~lanes});
    chk(chip_select_n, !hold);
    q = rsp_rdata;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_lane();
    logic [15:0] rd;
    xfer(1, 0, 0, 18'h00010, 2'b11, 16'hA55A, 4, rd);
    xfer(1, 0, 0, 18'h00010, 2'b01, 16'h1234, 4, rd);
    xfer(0, 0, 0, 18'h00010, 2'b11, 16'h0000, 4, rd);
    chk(rd, 16'hA534);
    xfer(1, 0, 0, 18'h00011, 2'b11, 16'hBEEF, 4, rd);
    xfer(0, 0, 0, 18'h00011, 2'b01, 16'h0000, 4, rd);
    chk(rd, 16'hA5EF);
  endtask
  task automatic t_byte();
    logic [15:0] rd;
    xfer(1, 1, 0, 18'h20020, 2'b00, 16'h0077, 4, rd);
    xfer(1, 1, 0, 18'h00020, 2'b00, 16'h0088, 4, rd);
    xfer(0, 0, 0, 18'h00020, 2'b11, 16'h0000, 4, rd);
    chk(rd, 16'h7788);
  endtask
  // Page held open: only column bits move, so later accesses skip the setup count
  task automatic t_page();
    logic [15:0] rd;
    for (int i = 0; i < 4; i++) begin
      xfer(1, 0, 1, 18'h00040 + 18'(i), 2'b11, 16'hC0D0 + 16'(i), (i == 0) ? 4 : 3, rd);
    end
    for (int i = 0; i < 4; i++) begin
      xfer(0, 0, i < 3, 18'h00040 + 18'(i), 2'b11, 16'h0000, 3, rd);
      chk(rd, 16'hC0D0 + 16'(i));
    end
  endtask
  // ----------------------------------------
  // Clock, main sequence, watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_byte_mode = 1'b0;
    req_hold_cs = 1'b0;
    req_addr = '0;
    req_lane_en = 2'b00;
    req_wdata = 16'h0000;
    repeat (9) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({chip_select_n, write_enable_n, output_enable_n, mem_dq_oe_n, req_ready}, 5'b11110);
    @(posedge sys_clk);
    rst <= 1'b0;
    t_lane();
    t_byte();
    t_page();
    final_report();
  end
  // Whole run is about a hundred cycles; this cuts a hang
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    final_report();
  end
endmodule // testbench
